// *** pos_drv_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// Gate drivers on the four pins, with pull-downs on the board side.
module pos_drv_model (
  // Clock
  input wire logic aclk,
  // Pins from the block
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_out_oe_n,
  // Levels seen by the drivers
  output logic [3:0] pin,
  output var int overlaps
);
  // A released pin is pulled low, so a floating safe state reads as off.
  assign pin = ~pwm_out_oe_n & pwm_out;

  // Both switches of the A/B leg on together would short the supply.
  initial
  begin
    overlaps = 0;
    forever
    begin
      @(posedge aclk);
      if (pin[0] && pin[1])
        overlaps <= overlaps + 1;
    end
  end
endmodule // pos_drv_model

`default_nettype wire

// *** pos_pkg.sv ***
// How it works
// - Shutdown source comes from the three-bit select field, bits 6 to 4.
// - 000 off, 001 comparator one, 010 comparator two, 011 either, 1xx adds pin.
// - Firmware writing one to the event flag is itself a shutdown event.
// - Event flag in bit 7 reads one from a shutdown event until cleared, zero in normal running.
// - A shutdown event sets the flag; it stays until firmware or restart clears.
// - Enabled outputs take their shutdown states at once, not on a clock edge.
// - Pair A and C safe state from bits 3-2: low, high, or floating.
// - Pair B and D safe state from bits 1-0, same encoding.
// - Shutdown is a level and lasts while the selected source stays asserted.
// - Firmware writes to the event flag are ignored while the condition holds.
// - After restart the waveform resumes only at the next period start.
// - Auto-restart bit set: hardware clears the flag; clear: firmware must.
// - Auto-restart keeps flag while active, re-enables pins at next period.
// - Half-bridge dead band delays only inactive-to-active transitions.
// - Seven-bit count delays each active edge by that many instruction cycles.
// - A count longer than the duty cycle keeps that output inactive.
// - Half-bridge drives the waveform on A and its complement on B.
// - Steering works only with mode field 11 and output config 00.
// - Steer bits 0 to 3 route the waveform to A to D, else port control.
// - The polarity field sets active level of every steered pin.
// - In steering mode shutdown touches only the steered pins.
// - Steer sync bit 4: one applies at next period, zero at instruction edge.
// - Pair select bits 7-6: 00 steer bits, 01 A-B, 10 A-C, 11 A-D.
package pos_pkg;

  localparam logic [7:0] OFF_ASC = 8'h00;
  localparam logic [7:0] OFF_DEL = 8'h04;
  localparam logic [7:0] OFF_STR = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;

  localparam logic [7:0] ASC_RST = 8'h00;
  localparam logic [7:0] DEL_RST = 8'h00;
  localparam logic [7:0] STR_RST = 8'h01;
  localparam logic [7:0] MODE_RST = 8'h00;

  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam int SRC_C1_BIT = 0;
  localparam int SRC_C2_BIT = 1;
  localparam int SRC_PIN_BIT = 2;

  localparam logic [1:0] PSS_HIGH = 2'h1;
  localparam int PSS_HIZ_BIT = 1;

  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CMPL_STEER = 2'h0;
  localparam logic [3:0] PIN_A = 4'h1;
  localparam logic [3:0] PAIR_AB = 4'h3;

  localparam int TCY_OSC = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic sef;
    logic [2:0] src;
    logic [1:0] ac;
    logic [1:0] bd;
  } pos_asc_t;

  typedef struct packed {
    logic rsen;
    logic [6:0] dbc;
  } pos_del_t;

  typedef struct packed {
    logic [1:0] cmpl;
    logic rsvd;
    logic sync;
    logic [3:0] str;
  } pos_str_t;

  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] rsvd;
    logic [1:0] mode;
    logic [1:0] pol;
  } pos_mode_t;

  typedef struct packed {
    logic c2;
    logic c1;
    logic pin_n;
  } pos_flt_t;

  localparam pos_flt_t FLT_IDLE = 3'h1;

endpackage

// *** pos_top.sv ***
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Holds an active edge back by a number of instruction cycles.
module pos_dband #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic [W-1:0] delay,
  // Waveform
  input wire logic in_act,
  output logic out_act
);

  logic [W-1:0] cnt_q;

  // Counting runs on the instruction tick, so the real delay may come in
  // up to one instruction cycle short; a falling input always wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      out_act <= 1'b0;
    end
    else if (!in_act)
    begin
      cnt_q <= delay;
      out_act <= 1'b0;
    end
    else if (cnt_q == '0)
    begin
      out_act <= 1'b1;
    end
    else if (tick)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  a_fall_fast: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_act |=> !out_act)
    else $error("dead band delayed an inactive edge");

  a_rise_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(in_act) && delay != '0 |=> !out_act)
    else $error("active edge not delayed");

endmodule // pos_dband

module pos_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PWM core
  input wire logic pwm_wave,
  input wire logic period_start,
  // Fault sources
  input wire logic fault_input_pin,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  // Port latches, bit 0 is A
  input wire logic [3:0] port_data,
  input wire logic [3:0] port_oe_n,
  // Pins, bit 0 is A
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_out_oe_n,
  output logic shutdown_active
);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pos_pkg::pos_asc_t asc_q;
  pos_pkg::pos_del_t del_q;
  pos_pkg::pos_str_t str_q;
  pos_pkg::pos_mode_t mode_q;
  pos_pkg::pos_asc_t wasc;
  pos_pkg::pos_flt_t s1_q, s2_q, s3_q, f_q;
  logic aw_hold_q, w_hold_q, wstrb0_q, do_wr;
  logic [ADDR_W-1:0] awaddr_q, wa, ra;
  logic [31:0] wdata_q;
  logic [7:0] rd_d;
  logic wr_hit, rd_hit;
  logic wr_asc, wr_del, wr_str, wr_mode;
  logic cond, fw_set, fw_clr, sef_d, hold_q, sd_act;
  logic [1:0] div_q;
  logic tcy_en, upd_steer, single, half, db_a, db_b;
  logic [3:0] steer_q, en, act;

  // Write channel: address and data may arrive in either order.
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign do_wr = aw_hold_q && w_hold_q;
  assign wa = {awaddr_q[ADDR_W-1:2], 2'b00};
  assign wr_hit = wa == ADDR_W'(pos_pkg::OFF_ASC)
    || wa == ADDR_W'(pos_pkg::OFF_DEL)
    || wa == ADDR_W'(pos_pkg::OFF_STR)
    || wa == ADDR_W'(pos_pkg::OFF_MODE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pos_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? pos_pkg::RESP_OKAY : pos_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits; other lanes are dropped.
  assign wr_asc = do_wr && wstrb0_q && wa == ADDR_W'(pos_pkg::OFF_ASC);
  assign wr_del = do_wr && wstrb0_q && wa == ADDR_W'(pos_pkg::OFF_DEL);
  assign wr_str = do_wr && wstrb0_q && wa == ADDR_W'(pos_pkg::OFF_STR);
  assign wr_mode = do_wr && wstrb0_q && wa == ADDR_W'(pos_pkg::OFF_MODE);
  assign wasc = wdata_q[7:0];

  // Read channel.
  assign s_axi_arready = !s_axi_rvalid;
  assign ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  always_comb
  begin
    rd_hit = 1'b1;
    rd_d = 8'h00;
    if (ra == ADDR_W'(pos_pkg::OFF_ASC))
      rd_d = asc_q;
    else if (ra == ADDR_W'(pos_pkg::OFF_DEL))
      rd_d = del_q;
    else if (ra == ADDR_W'(pos_pkg::OFF_STR))
      rd_d = str_q;
    else if (ra == ADDR_W'(pos_pkg::OFF_MODE))
      rd_d = mode_q;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pos_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_d};
      s_axi_rresp <= rd_hit ? pos_pkg::RESP_OKAY : pos_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control registers; reserved bits are never stored so they read zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      del_q <= pos_pkg::DEL_RST;
      str_q <= pos_pkg::STR_RST;
      mode_q <= pos_pkg::MODE_RST;
    end
    else
    begin
      if (wr_del)
        del_q <= wdata_q[7:0];
      if (wr_str)
      begin
        str_q <= wdata_q[7:0];
        str_q.rsvd <= 1'b0;
      end
      if (wr_mode)
      begin
        mode_q <= wdata_q[7:0];
        mode_q.rsvd <= 2'h0;
      end
    end
  end

  // Fault inputs are asynchronous; a change counts once stages 2 and 3
  // agree, which trades two cycles of latency for glitch immunity.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= pos_pkg::FLT_IDLE;
      s2_q <= pos_pkg::FLT_IDLE;
      s3_q <= pos_pkg::FLT_IDLE;
      f_q <= pos_pkg::FLT_IDLE;
    end
    else
    begin
      s1_q <= {comparator_two_output, comparator_one_output,
        fault_input_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  // Each select bit adds one source, which yields every documented code.
  assign cond = (asc_q.src[pos_pkg::SRC_PIN_BIT] && !f_q.pin_n)
    || (asc_q.src[pos_pkg::SRC_C1_BIT] && f_q.c1)
    || (asc_q.src[pos_pkg::SRC_C2_BIT] && f_q.c2);

  assign fw_set = wr_asc && wasc.sef;
  assign fw_clr = wr_asc && !wasc.sef && !cond;

  always_comb
  begin
    sef_d = asc_q.sef;
    if (cond || fw_set)
      sef_d = 1'b1;
    else if (del_q.rsen)
      sef_d = 1'b0;
    else if (fw_clr)
      sef_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      asc_q <= pos_pkg::ASC_RST;
    end
    else
    begin
      asc_q.sef <= sef_d;
      if (wr_asc)
      begin
        asc_q.src <= wasc.src;
        asc_q.ac <= wasc.ac;
        asc_q.bd <= wasc.bd;
      end
    end
  end

  // Pins stay forced until a period boundary after flag and cause are gone.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hold_q <= 1'b0;
    else if (cond || asc_q.sef)
      hold_q <= 1'b1;
    else if (period_start)
      hold_q <= 1'b0;
  end

  assign sd_act = cond || asc_q.sef || hold_q;
  assign shutdown_active = sd_act;

  // Instruction cycle enable.
  assign tcy_en = div_q == 2'(pos_pkg::TCY_OSC - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 2'h0;
    else
      div_q <= tcy_en ? 2'h0 : div_q + 2'h1;
  end

  assign upd_steer = str_q.sync ? period_start : tcy_en;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      steer_q <= pos_pkg::STR_RST[3:0];
    else if (upd_steer)
      steer_q <= str_q.str;
  end

  pos_dband #(
    .W(7)
  ) u_db_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tcy_en),
    .delay(del_q.dbc),
    .in_act(pwm_wave),
    .out_act(db_a)
  );

  pos_dband #(
    .W(7)
  ) u_db_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tcy_en),
    .delay(del_q.dbc),
    .in_act(!pwm_wave),
    .out_act(db_b)
  );

  assign single = mode_q.mode == pos_pkg::MODE_PWM
    && mode_q.cfg == pos_pkg::CFG_SINGLE;
  assign half = mode_q.cfg == pos_pkg::CFG_HALF;

  always_comb
  begin
    en = pos_pkg::PIN_A;
    act = {3'b000, pwm_wave};
    if (single && str_q.cmpl == pos_pkg::CMPL_STEER)
    begin
      en = steer_q;
      act = {4{pwm_wave}};
    end
    else if (single)
    begin
      en = pos_pkg::PIN_A | (pos_pkg::PIN_A << str_q.cmpl);
      act = {~pwm_wave, ~pwm_wave, ~pwm_wave, pwm_wave};
    end
    else if (half)
    begin
      en = pos_pkg::PAIR_AB;
      act = {2'b00, db_b, db_a};
    end
  end

  // Pins A and C are even, B and D odd, for polarity and safe state.
  always_comb
  begin
    pwm_out = 4'h0;
    pwm_out_oe_n = 4'hf;
    for (int i = 0; i < 4; i++)
    begin
      if (!en[i])
      begin
        pwm_out[i] = port_data[i];
        pwm_out_oe_n[i] = port_oe_n[i];
      end
      else if (sd_act && i % 2 == 0)
      begin
        pwm_out[i] = asc_q.ac == pos_pkg::PSS_HIGH;
        pwm_out_oe_n[i] = asc_q.ac[pos_pkg::PSS_HIZ_BIT];
      end
      else if (sd_act)
      begin
        pwm_out[i] = asc_q.bd == pos_pkg::PSS_HIGH;
        pwm_out_oe_n[i] = asc_q.bd[pos_pkg::PSS_HIZ_BIT];
      end
      else
      begin
        pwm_out[i] = act[i] ^ mode_q.pol[1 - i % 2];
        pwm_out_oe_n[i] = 1'b0;
      end
    end
  end

  a_src_off: assert property (
    asc_q.src == pos_pkg::SRC_OFF |-> !cond)
    else $error("disabled source still shuts down");

  a_src_comp: assert property (
    asc_q.src == 3'h3 && f_q.c2 |-> cond)
    else $error("either-comparator code missed comparator two");

  a_fw_set: assert property (
    fw_set |=> asc_q.sef && sd_act)
    else $error("firmware set did not shut down");

  a_flag_set: assert property (
    cond |=> asc_q.sef)
    else $error("condition did not set the flag");

  a_force_now: assert property (
    cond && en[0] && asc_q.ac == pos_pkg::PSS_HIGH
      |-> pwm_out[0] && !pwm_out_oe_n[0])
    else $error("pin A not forced high at once");

  a_hiz_pair: assert property (
    sd_act && en[3] && asc_q.bd[1] |-> pwm_out_oe_n[3])
    else $error("pin D not floating in shutdown");

  a_wr_ignored: assert property (
    wr_asc && !wasc.sef && cond |=> asc_q.sef)
    else $error("flag cleared while condition held");

  a_restart_edge: assert property (
    $fell(sd_act) |-> $past(period_start))
    else $error("restart off a period boundary");

  a_auto_clear: assert property (
    del_q.rsen && asc_q.sef && !cond && !fw_set |=> !asc_q.sef)
    else $error("auto restart did not clear the flag");

  a_manual_keep: assert property (
    !del_q.rsen && asc_q.sef && !wr_asc |=> asc_q.sef)
    else $error("flag cleared without firmware");

  a_single_only: assert property (
    !single |-> !en[3] && !en[2])
    else $error("steering outside single mode");

  a_port_pin: assert property (
    !en[2] |-> pwm_out[2] == port_data[2]
      && pwm_out_oe_n[2] == port_oe_n[2])
    else $error("pin C left port control");

  a_steer_sync: assert property (
    $changed(steer_q) && $past(str_q.sync) |-> $past(period_start))
    else $error("synced steering moved mid period");

  a_cmpl_pair: assert property (
    single && str_q.cmpl == 2'h2 |-> en == 4'h5)
    else $error("pair A-C not selected");

endmodule // pos_top

`default_nettype wire

// *** pwm_output_protect_steer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module pwm_output_protect_steer_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic pwm_wave = 0, period_start = 0, flt_pin = 1, cmp1 = 0, cmp2 = 0;
  logic [3:0] port_data = 0;
  logic [3:0] port_oe_n = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sd;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, d;
  logic [3:0] pout, poe, pin;
  logic [15:0] lfsr = 16'h002d;
  int overlaps;
  int mismatches = 0;
  int n_tests = 0;

  pos_top u_pos_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_wave(pwm_wave),
    .period_start(period_start), .fault_input_pin(flt_pin),
    .comparator_one_output(cmp1), .comparator_two_output(cmp2),
    .port_data(port_data), .port_oe_n(port_oe_n), .pwm_out(pout),
    .pwm_out_oe_n(poe), .shutdown_active(sd));

  pos_drv_model u_pos_drv_model (.aclk(aclk), .pwm_out(pout),
    .pwm_out_oe_n(poe), .pin(pin), .overlaps(overlaps));

  initial forever #2.5 aclk = ~aclk;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Pin A and C follow pol[1], pin B and D follow pol[0].
  function automatic logic [3:0] pin_exp(input logic [3:0] en,
    input logic w, input logic [1:0] pol, input logic [3:0] pd);
    for (int i = 0; i < 4; i++)
      pin_exp[i] = en[i] ? w ^ pol[(i % 2) == 0] : pd[i];
  endfunction

  // Source 0 is the fault pin, 1 and 2 the comparators.
  function automatic logic src_hit(input logic [2:0] s, input int f);
    return (f == 0) ? s[2] : s[f - 1];
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic pulse();
    @(posedge aclk) period_start <= 1;
    @(posedge aclk) period_start <= 0;
  endtask

  task automatic fault(input int f, input logic v);
    @(posedge aclk);
    case (f)
      0: flt_pin <= ~v;
      1: cmp1 <= v;
      default: cmp2 <= v;
    endcase
  endtask

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs well under 10000 cycles.
  initial
  begin
    tick(20000);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    logic [15:0] r, r2;
    logic a;
    int o;
    tick(12);
    aresetn <= 1;
    // Out of reset only pin A carries the waveform; B to D stay on the port.
    @(posedge aclk) pwm_wave <= 1;
    port_data <= 4'h6;
    @(negedge aclk);
    cmp({poe, pout}, 8'he7);
    rd(pos_pkg::OFF_ASC); cmp(d, pos_pkg::ASC_RST);
    rd(pos_pkg::OFF_DEL); cmp(d, pos_pkg::DEL_RST);
    rd(pos_pkg::OFF_STR); cmp(d, pos_pkg::STR_RST);
    rd(8'h10); cmp(rs, pos_pkg::RESP_SLVERR);
    wr(8'h10, 8'hff); cmp(rs, pos_pkg::RESP_SLVERR);
    wr(pos_pkg::OFF_STR, 8'hef); rd(pos_pkg::OFF_STR); cmp(d, 8'hcf);
    $display("test registers done");

    for (int k = 0; k < 12; k++)
    begin
      r = rnd();
      @(posedge aclk) port_data <= r[11:8];
      port_oe_n <= r[15:12];
      wr(pos_pkg::OFF_MODE, {4'h0, 2'b11, r[5:4]});
      wr(pos_pkg::OFF_STR, {4'h0, r[3:0]});
      tick(8);
      repeat (2)
      begin
        r2 = rnd();
        @(posedge aclk) pwm_wave <= r2[0];
        tick(2);
        @(negedge aclk);
        cmp(pout, pin_exp(r[3:0], r2[0], r[5:4], r[11:8]));
        cmp(poe, ~r[3:0] & r[15:12]);
      end
    end
    wr(pos_pkg::OFF_MODE, 8'h0c);
    for (int c = 1; c < 4; c++)
    begin
      wr(pos_pkg::OFF_STR, {c[1:0], 6'h0});
      tick(8);
      for (int w = 0; w < 2; w++)
      begin
        @(posedge aclk) pwm_wave <= w[0];
        tick(2);
        @(negedge aclk);
        cmp({pout[0], pout[c]}, {w[0], ~w[0]});
      end
    end
    wr(pos_pkg::OFF_STR, 8'h11);
    // A synced update waits for a period start, so give it one.
    pulse();
    tick(8);
    @(posedge aclk) pwm_wave <= 1;
    port_data <= 4'h0;
    wr(pos_pkg::OFF_STR, 8'h12);
    tick(8);
    @(negedge aclk); cmp(pout[1:0], 2'b01);
    pulse();
    tick(2);
    @(negedge aclk); cmp(pout[1:0], 2'b10);
    $display("test steering done");

    wr(pos_pkg::OFF_STR, 8'h03);
    wr(pos_pkg::OFF_ASC, 8'h16);
    @(posedge aclk) pwm_wave <= 0;
    port_data <= 4'ha;
    port_oe_n <= 4'h0;
    fault(1, 1);
    tick(8);
    @(negedge aclk);
    cmp(pout[0], 1);
    cmp(poe[1:0], 2'b10);
    cmp(pin[1], 0);
    cmp({poe[3:2], pout[3:2]}, 4'h2);
    cmp(sd, 1);
    wr(pos_pkg::OFF_ASC, 8'h16); rd(pos_pkg::OFF_ASC); cmp(d, 8'h96);
    fault(1, 0);
    tick(8);
    rd(pos_pkg::OFF_ASC); cmp(d, 8'h96);
    wr(pos_pkg::OFF_ASC, 8'h16); rd(pos_pkg::OFF_ASC); cmp(d, 8'h16);
    @(negedge aclk); cmp(sd, 1);
    pulse();
    tick(1);
    @(negedge aclk); cmp({sd, poe[1:0], pout[1:0]}, 5'h0);
    wr(pos_pkg::OFF_ASC, 8'h80); rd(pos_pkg::OFF_ASC); cmp(d[7], 1);
    @(negedge aclk); cmp(sd, 1);
    wr(pos_pkg::OFF_ASC, 8'h00);
    pulse();
    tick(1);
    @(negedge aclk); cmp(sd, 0);
    $display("test shutdown done");

    wr(pos_pkg::OFF_DEL, 8'h80);
    for (int s = 0; s < 8; s++)
      for (int f = 0; f < 3; f++)
      begin
        wr(pos_pkg::OFF_ASC, {1'b0, s[2:0], 4'h0});
        fault(f, 1);
        tick(8);
        rd(pos_pkg::OFF_ASC); cmp(d[7], src_hit(s[2:0], f));
        fault(f, 0);
        tick(8);
        rd(pos_pkg::OFF_ASC); cmp(d[7], 0);
        @(negedge aclk); cmp(sd, src_hit(s[2:0], f));
        pulse();
        tick(1);
        @(negedge aclk); cmp(sd, 0);
      end
    $display("test sources done");

    wr(pos_pkg::OFF_ASC, 8'h00);
    wr(pos_pkg::OFF_DEL, 8'h03);
    wr(pos_pkg::OFF_MODE, 8'h8c);
    o = overlaps;
    a = 0;
    tick(30);
    @(posedge aclk) pwm_wave <= 1;
    repeat (4) @(negedge aclk) a = a | pout[0];
    @(posedge aclk) pwm_wave <= 0;
    repeat (16) @(negedge aclk) a = a | pout[0];
    cmp(a, 0);
    tick(20);
    @(posedge aclk) pwm_wave <= 1;
    tick(2);
    @(negedge aclk); cmp(pout[1:0], 2'b00);
    tick(5);
    @(negedge aclk); cmp(pout[0], 0);
    tick(7);
    @(negedge aclk); cmp(pout[1:0], 2'b01);
    cmp(overlaps, o);
    $display("test dead band done");
    end_of_test();
  end
endmodule // pwm_output_protect_steer_tb

`default_nettype wire
